// ==== common/strap_pkg.sv ====
// Shared constants and types for the boot strap sampler.
// Assumes a single 50 MHz system clock and an asynchronous active-high reset.
package strap_pkg;

  // Strap positions within the five-bit status word
  localparam int STRAP_COUNT = 5;
  localparam int IDX_TDI = 0;   // test_data_in_strap, regulator voltage
  localparam int IDX_PIN0 = 1;  // boot_select_pin_zero
  localparam int IDX_PIN2 = 2;  // boot_select_pin_two
  localparam int IDX_TDO = 3;   // test_data_out_strap, boot log and sdio input edge
  localparam int IDX_PIN5 = 4;  // sdio_edge_strap_pin, sdio output edge

  // Default weak pulls during the sampling window
  localparam logic [STRAP_COUNT-1:0] PULL_UP_MASK = 5'h1a;
  localparam logic [STRAP_COUNT-1:0] PULL_DOWN_MASK = 5'h05;

  // Synchroniser depth and the settle time that follows reset release
  localparam int SYNC_STAGES = 2;
  localparam int CTRL_COUNT = 3;
  localparam int CTRL_CHIP_EN = 0;
  localparam int CTRL_WDT = 1;
  localparam int CTRL_BROWNOUT = 2;
  localparam logic [1:0] SETTLE_LAST = 2'(SYNC_STAGES);
  localparam logic [1:0] SETTLE_ZERO = 2'h0;
  localparam logic [1:0] SETTLE_STEP = 2'h1;

  // Sdio edge code bits: one means rising edge
  localparam int SDIO_IN_BIT = 1;
  localparam int SDIO_OUT_BIT = 0;

  // Idle level of the serial transmit line
  localparam logic TX_IDLE = 1'b1;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b10
  } phase_t;

endpackage

// ==== logic/strap_sync.sv ====
// Multi-bit two-flop synchroniser for pin and reset-source levels.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ps
module strap_sync import strap_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// ==== logic/strap_decode.sv ====
// Turns the five strap bits plus firmware overrides into boot settings.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module strap_decode import strap_pkg::*; (
  input wire logic [STRAP_COUNT-1:0] strap_i,
  input wire logic ldo_override_en_i,
  input wire logic ldo_override_1v8_i,
  input wire logic sdio_override_en_i,
  input wire logic [1:0] sdio_override_code_i,
  output logic ldo_1v8_o,
  output logic boot_from_flash_o,
  output logic download_boot_o,
  output logic boot_mode_invalid_o,
  output logic boot_log_en_o,
  output logic sdio_in_rising_o,
  output logic sdio_out_rising_o
);

  logic [1:0] sdio_code;

  // Firmware override wins over the strapped values once set
  always_comb begin
    ldo_1v8_o = ldo_override_en_i ? ldo_override_1v8_i : strap_i[IDX_TDI];
    sdio_code = sdio_override_en_i ? sdio_override_code_i
                                   : {strap_i[IDX_TDO], strap_i[IDX_PIN5]};
    sdio_in_rising_o = sdio_code[SDIO_IN_BIT];
    sdio_out_rising_o = sdio_code[SDIO_OUT_BIT];
  end

  // Pin two only matters when pin zero is low
  always_comb begin
    boot_from_flash_o = strap_i[IDX_PIN0];
    download_boot_o = !strap_i[IDX_PIN0] && !strap_i[IDX_PIN2];
    // Zero with pin two high selects no documented mode
    boot_mode_invalid_o = !strap_i[IDX_PIN0] && strap_i[IDX_PIN2];
    boot_log_en_o = strap_i[IDX_TDO];
  end

endmodule

// ==== logic/boot_strap_latch.sv ====
// Boot strap sampler: pulls, samples and holds five strap pins, then
// hands the pins to their normal functions and publishes boot settings.
// Assumes pins arrive asynchronously and function logic runs on sys_clk_i.
// Assumes chip enable and the reset sources are levels held for at least one cycle;
// a shorter pulse may be lost in the synchronisers.
// Assumes the pads apply the pull enables; no strap pin is driven before hand-over.
`timescale 1ns/1ps
module boot_strap_latch import strap_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic chip_en_i,
  input wire logic wdt_reset_i,
  input wire logic brownout_reset_i,
  input wire logic test_data_in_strap_i,
  input wire logic boot_select_pin_zero_i,
  input wire logic boot_select_pin_two_i,
  input wire logic test_data_out_strap_i,
  input wire logic sdio_edge_strap_pin_i,
  output logic [STRAP_COUNT-1:0] strap_pin_out_o,
  output logic [STRAP_COUNT-1:0] strap_pin_oe_o,
  output logic [STRAP_COUNT-1:0] pull_up_en_o,
  output logic [STRAP_COUNT-1:0] pull_down_en_o,
  input wire logic [STRAP_COUNT-1:0] func_out_i,
  input wire logic [STRAP_COUNT-1:0] func_oe_i,
  output logic [STRAP_COUNT-1:0] func_in_o,
  input wire logic uart_tx_i,
  input wire logic boot_done_i,
  output logic first_serial_transmit_o,
  input wire logic ldo_override_en_i,
  input wire logic ldo_override_1v8_i,
  input wire logic sdio_override_en_i,
  input wire logic [1:0] sdio_override_code_i,
  output logic [STRAP_COUNT-1:0] strap_status_o,
  output logic strap_valid_o,
  output logic ldo_1v8_o,
  output logic boot_from_flash_o,
  output logic download_boot_o,
  output logic boot_mode_invalid_o,
  output logic boot_log_en_o,
  output logic sdio_in_rising_o,
  output logic sdio_out_rising_o,
  output logic chip_active_o
);

  // All state in one record; next_s is its combinational copy
  typedef struct packed {
    phase_t phase;
    logic [1:0] settle;
    logic [STRAP_COUNT-1:0] strap;
    logic valid;
    logic [STRAP_COUNT-1:0] pin_out;
    logic [STRAP_COUNT-1:0] pin_oe;
    logic [STRAP_COUNT-1:0] pull_up;
    logic [STRAP_COUNT-1:0] pull_down;
    logic [STRAP_COUNT-1:0] func_in;
    logic tx;
    logic ldo_1v8;
    logic boot_flash;
    logic boot_dl;
    logic boot_bad;
    logic log_en;
    logic sdio_in_r;
    logic sdio_out_r;
  } state_t;

  state_t s;
  state_t next_s;

  // Pin and control levels before and after the two-flop stage
  logic [STRAP_COUNT-1:0] pins_raw;
  logic [STRAP_COUNT-1:0] pins_sync;
  logic [CTRL_COUNT-1:0] ctrl_raw;
  logic [CTRL_COUNT-1:0] ctrl_sync;
  logic rearm;

  // Decoded settings, registered below so no setting output is combinational
  logic dec_ldo_1v8;
  logic dec_boot_flash;
  logic dec_boot_dl;
  logic dec_boot_bad;
  logic dec_log_en;
  logic dec_sdio_in_r;
  logic dec_sdio_out_r;

  // Phase test shared by the pin hand-over, the serial gate and the chip-active output
  function automatic logic in_run(input phase_t phase);
    return phase == ST_RUN;
  endfunction

  // Settling ends once the synchroniser has filled with the released levels
  function automatic logic settle_done(input logic [1:0] count);
    return count == SETTLE_LAST;
  endfunction

  // Boot log reaches the line when strapped on, or freely once boot is over
  function automatic logic log_open(input logic strap_tdo, input logic done);
    return strap_tdo || done;
  endfunction

  // Gather the five strap pins in status-word order
  always_comb begin
    pins_raw[IDX_TDI] = test_data_in_strap_i;
    pins_raw[IDX_PIN0] = boot_select_pin_zero_i;
    pins_raw[IDX_PIN2] = boot_select_pin_two_i;
    pins_raw[IDX_TDO] = test_data_out_strap_i;
    pins_raw[IDX_PIN5] = sdio_edge_strap_pin_i;
  end

  // Reset sources and chip enable come from other domains
  always_comb begin
    ctrl_raw[CTRL_CHIP_EN] = chip_en_i;
    ctrl_raw[CTRL_WDT] = wdt_reset_i;
    ctrl_raw[CTRL_BROWNOUT] = brownout_reset_i;
  end

  // Pins pass two flops before any logic reads them
  strap_sync #(
    .WIDTH(STRAP_COUNT)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(pins_raw),
    .sync_o(pins_sync)
  );

  // Reset sources likewise; a pulse shorter than a cycle may be missed
  strap_sync #(
    .WIDTH(CTRL_COUNT)
  ) u_ctrl_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(ctrl_raw),
    .sync_o(ctrl_sync)
  );

  // Decoding works on the held straps, never on live pins
  strap_decode u_decode (
    .strap_i(s.strap),
    .ldo_override_en_i(ldo_override_en_i),
    .ldo_override_1v8_i(ldo_override_1v8_i),
    .sdio_override_en_i(sdio_override_en_i),
    .sdio_override_code_i(sdio_override_code_i),
    .ldo_1v8_o(dec_ldo_1v8),
    .boot_from_flash_o(dec_boot_flash),
    .download_boot_o(dec_boot_dl),
    .boot_mode_invalid_o(dec_boot_bad),
    .boot_log_en_o(dec_log_en),
    .sdio_in_rising_o(dec_sdio_in_r),
    .sdio_out_rising_o(dec_sdio_out_r)
  );

  // Watchdog, brownout or a low chip enable all reopen sampling
  always_comb begin
    rearm = !ctrl_sync[CTRL_CHIP_EN] || ctrl_sync[CTRL_WDT]
            || ctrl_sync[CTRL_BROWNOUT];
  end

  // Phase sequencing, latch capture and pin handover
  always_comb begin
    // Everything not named below keeps its value
    next_s = s;
    unique case (s.phase)
      ST_HOLD: begin
        // Transparent while reset stands
        next_s.strap = pins_sync;
        next_s.valid = 1'b0;
        next_s.settle = SETTLE_ZERO;
        // Leave only once every reset source has cleared
        if (!rearm) begin
          next_s.phase = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // Wait out the synchroniser so captured levels are the released ones
        next_s.strap = pins_sync;
        if (rearm) begin
          next_s.phase = ST_HOLD;
        end else if (settle_done(s.settle)) begin
          next_s.phase = ST_RUN;
          next_s.valid = 1'b1;
        end else begin
          next_s.settle = s.settle + SETTLE_STEP;
        end
      end
      ST_RUN: begin
        // Straps frozen; only a new reset or power-down reopens them
        if (rearm) begin
          next_s.phase = ST_HOLD;
          next_s.valid = 1'b0;
        end
      end
      default: begin
        next_s.phase = ST_HOLD;
      end
    endcase

    // Pulls on and drivers off until the pins are handed over
    if (in_run(next_s.phase)) begin
      next_s.pull_up = '0;
      next_s.pull_down = '0;
      next_s.pin_out = func_out_i;
      next_s.pin_oe = func_oe_i;
      next_s.func_in = pins_sync;
    end else begin
      next_s.pull_up = PULL_UP_MASK;
      next_s.pull_down = PULL_DOWN_MASK;
      next_s.pin_out = '0;
      next_s.pin_oe = '0;
      next_s.func_in = '0;
    end

    // Boot log gate: held idle while silenced and boot is still running
    if (in_run(s.phase) && log_open(s.strap[IDX_TDO], boot_done_i)) begin
      next_s.tx = uart_tx_i;
    end else begin
      next_s.tx = TX_IDLE;
    end

    // Register decoded settings so every data output leaves a flop
    next_s.ldo_1v8 = dec_ldo_1v8;
    next_s.boot_flash = dec_boot_flash;
    next_s.boot_dl = dec_boot_dl;
    next_s.boot_bad = dec_boot_bad;
    next_s.log_en = dec_log_en;
    next_s.sdio_in_r = dec_sdio_in_r;
    next_s.sdio_out_r = dec_sdio_out_r;
  end

  // Reset parks the drivers with default pulls on and clears the captured straps to zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Sampling closed, nothing captured yet
      s.phase <= ST_HOLD;
      s.settle <= SETTLE_ZERO;
      s.strap <= '0;
      s.valid <= 1'b0;
      // Drivers parked and default pulls on
      s.pin_out <= '0;
      s.pin_oe <= '0;
      s.pull_up <= PULL_UP_MASK;
      s.pull_down <= PULL_DOWN_MASK;
      s.func_in <= '0;
      // Serial line idle, settings cleared
      s.tx <= TX_IDLE;
      s.ldo_1v8 <= 1'b0;
      s.boot_flash <= 1'b0;
      s.boot_dl <= 1'b0;
      s.boot_bad <= 1'b0;
      s.log_en <= 1'b0;
      s.sdio_in_r <= 1'b0;
      s.sdio_out_r <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // Pin drive and pulls straight from the state register
  always_comb begin
    strap_pin_out_o = s.pin_out;
    strap_pin_oe_o = s.pin_oe;
    pull_up_en_o = s.pull_up;
    pull_down_en_o = s.pull_down;
  end

  // Function side and the gated serial line
  always_comb begin
    func_in_o = s.func_in;
    first_serial_transmit_o = s.tx;
  end

  // Status word and its valid flag
  always_comb begin
    strap_status_o = s.strap;
    strap_valid_o = s.valid;
    chip_active_o = in_run(s.phase);
  end

  // Boot settings, already registered from the decoder
  always_comb begin
    ldo_1v8_o = s.ldo_1v8;
    boot_from_flash_o = s.boot_flash;
    download_boot_o = s.boot_dl;
    boot_mode_invalid_o = s.boot_bad;
    boot_log_en_o = s.log_en;
    sdio_in_rising_o = s.sdio_in_r;
    sdio_out_rising_o = s.sdio_out_r;
  end

endmodule

// ==== tb/strap_checker.sv ====
// Port assertions for the boot strap sampler.
// Assumes it is bound onto every boot_strap_latch instance.
`timescale 1ns/1ps
module strap_checker import strap_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic chip_en_i,
  input wire logic wdt_reset_i,
  input wire logic brownout_reset_i,
  input wire logic uart_tx_i,
  input wire logic boot_done_i,
  input wire logic sdio_override_en_i,
  input wire logic [4:0] pull_up_en_o,
  input wire logic [4:0] pull_down_en_o,
  input wire logic first_serial_transmit_o,
  input wire logic [4:0] strap_status_o,
  input wire logic strap_valid_o,
  input wire logic boot_from_flash_o,
  input wire logic download_boot_o,
  input wire logic sdio_in_rising_o,
  input wire logic sdio_out_rising_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Any reset source seen at the pins, before synchronising
  logic rearm;
  assign rearm = wdt_reset_i | brownout_reset_i | !chip_en_i;
  // Captured for two samples, so the registered decodes have caught up
  sequence steady;
    strap_valid_o && $past(strap_valid_o);
  endsequence
  AST_PULL_ON: assert property (!strap_valid_o |-> pull_up_en_o == PULL_UP_MASK
    && pull_down_en_o == PULL_DOWN_MASK) else $error("pulls wrong while sampling");
  AST_PULL_OFF: assert property (strap_valid_o |-> (pull_up_en_o | pull_down_en_o) == 5'h00)
    else $error("pulls left on after capture");
  AST_HOLD: assert property (steady |-> $stable(strap_status_o))
    else $error("captured straps moved");
  AST_BOOT: assert property (steady |-> boot_from_flash_o == strap_status_o[IDX_PIN0] &&
    download_boot_o == (strap_status_o[2:1] == 2'h0)) else $error("boot mode decode wrong");
  AST_SDIO: assert property (steady ##0 !$past(sdio_override_en_i) |->
    {sdio_in_rising_o, sdio_out_rising_o} == {strap_status_o[IDX_TDO], strap_status_o[IDX_PIN5]})
    else $error("sdio edge decode wrong");
  AST_SILENT: assert property ($past(strap_valid_o) && !$past(boot_done_i) &&
    !$past(strap_status_o[IDX_TDO]) |-> first_serial_transmit_o == TX_IDLE)
    else $error("serial line not silent");
  AST_LOG: assert property (steady ##0 $past(boot_done_i) |->
    first_serial_transmit_o == $past(uart_tx_i)) else $error("serial line not passed");
  AST_REARM: assert property ($past(rearm, 4) |-> !strap_valid_o)
    else $error("straps still valid after a reset source");
  cover property ($rose(strap_valid_o));
  cover property (steady ##0 download_boot_o);
  cover property (steady ##0 $past(boot_done_i));
endmodule
bind boot_strap_latch strap_checker chk_u (.sys_clk_i, .rst_i, .chip_en_i, .wdt_reset_i,
  .brownout_reset_i, .uart_tx_i, .boot_done_i, .sdio_override_en_i, .pull_up_en_o,
  .pull_down_en_o, .first_serial_transmit_o, .strap_status_o, .strap_valid_o,
  .boot_from_flash_o, .download_boot_o, .sdio_in_rising_o, .sdio_out_rising_o);

// ==== tb/strap_host.sv ====
// Far-side model of the five strap pins: host drive or floating.
// Assumes pull and drive enables come from the sampler.
`timescale 1ns/1ps
module strap_host (
  input wire logic sys_clk_i,
  input wire logic drive_i,
  input wire logic [4:0] level_i,
  input wire logic [4:0] pull_up_i,
  input wire logic [4:0] pull_down_i,
  input wire logic [4:0] oe_i,
  input wire logic [4:0] out_i,
  output logic [4:0] pin_o
);
  logic churn = 1'b0;
  // Unheld pins wander, so no stale level can pass for a real one
  always @(posedge sys_clk_i) churn <= ~churn;
  // Device drive wins, then the host, then the weak pulls
  always_comb begin
    for (int b = 0; b < 5; b++) begin
      pin_o[b] = oe_i[b] ? out_i[b] : drive_i ? level_i[b] :
        pull_up_i[b] ? 1'b1 : pull_down_i[b] ? 1'b0 : churn;
    end
  end
endmodule

// ==== tb/boot_strap_latch_tb_top.sv ====
// Self-checking bench for the boot strap sampler.
// Assumes strap_host resolves the pin levels.
`timescale 1ns/1ps
module boot_strap_latch_tb_top;
  import strap_pkg::*;
  // Stimulus and observed ports
  logic sys_clk_i = 1'b0, rst_i = 1'b1, chip_en_i = 1'b1, wdt_reset_i = 1'b0;
  logic brownout_reset_i = 1'b0, uart_tx_i = 1'b1, boot_done_i = 1'b0, drive = 1'b0;
  logic ldo_override_en_i = 1'b0, ldo_override_1v8_i = 1'b0, sdio_override_en_i = 1'b0;
  logic [1:0] sdio_override_code_i = 2'h0;
  logic [4:0] func_out_i = 5'h00, func_oe_i = 5'h00, level = 5'h00, pins, func_in_o;
  logic [4:0] strap_pin_out_o, strap_pin_oe_o, pull_up_en_o, pull_down_en_o, strap_status_o;
  logic first_serial_transmit_o, strap_valid_o, ldo_1v8_o, boot_from_flash_o, download_boot_o;
  logic boot_mode_invalid_o, boot_log_en_o, sdio_in_rising_o, sdio_out_rising_o, chip_active_o;
  logic [7:0] dec;
  int bad_count = 0;
  int checks = 0;
  assign dec = {1'b0, ldo_1v8_o, boot_from_flash_o, download_boot_o, boot_mode_invalid_o,
    boot_log_en_o, sdio_in_rising_o, sdio_out_rising_o};
  always #10 sys_clk_i = ~sys_clk_i;
  boot_strap_latch dut_u (.sys_clk_i, .rst_i, .chip_en_i, .wdt_reset_i, .brownout_reset_i,
    .test_data_in_strap_i(pins[IDX_TDI]), .boot_select_pin_zero_i(pins[IDX_PIN0]),
    .boot_select_pin_two_i(pins[IDX_PIN2]), .test_data_out_strap_i(pins[IDX_TDO]),
    .sdio_edge_strap_pin_i(pins[IDX_PIN5]), .strap_pin_out_o, .strap_pin_oe_o, .pull_up_en_o,
    .pull_down_en_o, .func_out_i, .func_oe_i, .func_in_o, .uart_tx_i, .boot_done_i,
    .first_serial_transmit_o, .ldo_override_en_i, .ldo_override_1v8_i, .sdio_override_en_i,
    .sdio_override_code_i, .strap_status_o, .strap_valid_o, .ldo_1v8_o, .boot_from_flash_o,
    .download_boot_o, .boot_mode_invalid_o, .boot_log_en_o, .sdio_in_rising_o,
    .sdio_out_rising_o, .chip_active_o);
  strap_host host_u (.sys_clk_i, .drive_i(drive), .level_i(level), .pull_up_i(pull_up_en_o),
    .pull_down_i(pull_down_en_o), .oe_i(strap_pin_oe_o), .out_i(strap_pin_out_o), .pin_o(pins));
  // Advance n edges, then settle just off the edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Same bit order as dec
  function automatic logic [7:0] expect_dec(input logic [4:0] s);
    return {1'b0, s[0], s[1], !s[1] && !s[2], !s[1] && s[2], s[3], s[3], s[4]};
  endfunction
  task automatic complete_run();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One reset source for three edges, then capture, hold and log checks
  task automatic capture(input int src, input logic [4:0] val, input logic drv);
    level = val;
    drive = drv;
    {rst_i, wdt_reset_i, brownout_reset_i, chip_en_i} = (src == 3) ? 4'h0 : ((4'h8 >> src) | 4'h1);
    step(3);
    check_val({6'h0, strap_valid_o, chip_active_o}, 8'h00);
    {rst_i, wdt_reset_i, brownout_reset_i, chip_en_i} = 4'h1;
    repeat (40) if (strap_valid_o !== 1'b1) step(1);
    step(2);
    check_val({2'h0, chip_active_o, strap_status_o}, {3'h1, val});
    check_val(dec, expect_dec(val));
    level = ~val;
    uart_tx_i = 1'b0;
    step(4);
    check_val({3'h0, strap_status_o}, {3'h0, val});
    check_val({7'h0, first_serial_transmit_o}, {7'h0, !val[3]});
    // Floating pins wander once the pulls are off, so only driven ones are compared
    if (drv) begin
      check_val({3'h0, func_in_o}, {3'h0, ~val});
    end
    uart_tx_i = 1'b1;
    $display("capture test src=%0d val=%h ended", src, val);
  endtask
  // Floating pins, corner straps, then random ones from a fixed seed
  initial begin
    static logic [4:0] corner [6] = '{5'h00, 5'h1f, 5'h04, 5'h11, 5'h08, 5'h02};
    void'($urandom(20));
    step(17);
    capture(0, PULL_UP_MASK, 1'b0);
    for (int i = 0; i < 22; i++) begin
      capture(i % 4, (i < 6) ? corner[i] : 5'($urandom), 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      {ldo_override_en_i, sdio_override_en_i} = 2'h3;
      ldo_override_1v8_i = i[0];
      sdio_override_code_i = 2'(i);
      step(2);
      check_val(dec & 8'h43, {1'b0, i[0], 4'h0, 2'(i)});
    end
    {ldo_override_en_i, sdio_override_en_i} = 2'h0;
    $display("override test ended");
    boot_done_i = 1'b1;
    repeat (8) begin
      {uart_tx_i, func_oe_i, func_out_i} = 11'($urandom);
      step(1);
      check_val({strap_pin_oe_o, 3'h0}, {func_oe_i, 3'h0});
      check_val({3'h0, strap_pin_out_o}, {3'h0, func_out_i});
      check_val({7'h0, first_serial_transmit_o}, {7'h0, uart_tx_i});
    end
    func_oe_i = 5'h00;
    $display("passthrough test ended");
    complete_run();
  end
  // Hang guard, far beyond the roughly 380 cycles the tests take
  initial begin
    #(20 * 20000);
    bad_count++;
    complete_run();
  end
endmodule
